// >>> verification/bcg_core_model.sv
// Purpose: Model of the CPU core and peripherals fed by the clock sets.
// Assumes: Clock outputs are sampled waveforms built on clk_i.
// Notes: Counts rising edges of each set; flags edges while clocks are inactive.
`timescale 1ns/1ps
`default_nettype none
module bcg_core_model (
  input wire logic clk_i, // System clock
  input wire logic cpu_clock_i, // CPU clock set
  input wire logic periph_clock_i, // Peripheral clock set
  input wire logic clocks_active_i, // Bus clocks running
  input wire logic clear_i, // Restart counts and flag
  output logic [15:0] cpu_edges_o, // CPU rising edges seen
  output logic [15:0] periph_edges_o, // Peripheral rising edges seen
  output logic idle_edge_o // Edge seen while clocks inactive
);
  logic cpu_q;
  logic per_q;
  logic act_q;
  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    cpu_q <= cpu_clock_i;
    per_q <= periph_clock_i;
    act_q <= clocks_active_i;
  end
  // Edge counts; the idle check skips the cycle after the drop, gates lag
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      cpu_edges_o <= 16'h0000;
      periph_edges_o <= 16'h0000;
      idle_edge_o <= 1'b0;
    end else begin
      if (cpu_clock_i && !cpu_q) cpu_edges_o <= cpu_edges_o + 16'h0001;
      if (periph_clock_i && !per_q) periph_edges_o <= periph_edges_o + 16'h0001;
      if (!clocks_active_i && !act_q && ((cpu_clock_i && !cpu_q) || (periph_clock_i && !per_q))) begin
        idle_edge_o <= 1'b1;
      end
    end
  end
endmodule : bcg_core_model
`default_nettype wire

// >>> verification/bus_clock_generator_bench.sv
// Purpose: Self-checking bench for the bus clock generator.
// Assumes: Osc half period 40 ns, VCO half period 50 ns, offset from clk edges.
// Notes: Osc falls are counted here to time start-up and stop recovery.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s expected %0d seen %0d", nm, exp, got); end end
module bus_clock_generator_bench;
  typedef struct {logic pll; logic wt; int bus_p; int base_p; logic cpu_run;} bcg_row_t;
  logic clk = 1'b0, reset_n = 1'b0, osc = 1'b0, vco = 1'b0, pll_sel = 1'b0;
  logic por = 1'b0, lvd = 1'b0, stop_req = 1'b0, wake = 1'b0, wait_m = 1'b0, long_rec = 1'b0;
  logic mdl_clr = 1'b1;
  logic base_clk, bus_clk, cpu_clk, per_clk, active, pin, pin_oe, idle_edge;
  logic [15:0] cpu_edges, per_edges;
  int error_cnt = 0, n_tests = 0, osc_falls = 0, mark = 0, p;
  bcg_row_t rows [4] = '{'{1'b0, 1'b0, 32, 16, 1'b1}, '{1'b1, 1'b0, 60, 30, 1'b1},
                         '{1'b0, 1'b1, 32, 16, 1'b0}, '{1'b1, 1'b1, 60, 30, 1'b0}};
  // ----------------------------------------------------------------
  // Clocks and instances
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // Offsets keep pin edges away from every clk edge
  initial begin #2; forever #40 osc = ~osc; end
  initial begin #3; forever #50 vco = ~vco; end
  always @(negedge osc) osc_falls++;
  bcg_bus_clock_gen i_bcg_bus_clock_gen (.clk_i(clk), .reset_n_i(reset_n), .osc_clock_i(osc),
    .vco_clock_i(vco), .pll_select_i(pll_sel), .por_i(por), .low_voltage_detect_i(lvd),
    .stop_req_i(stop_req), .wake_i(wake), .wait_i(wait_m), .long_recovery_i(long_rec),
    .base_clock_out_o(base_clk), .bus_clock_o(bus_clk), .cpu_clock_o(cpu_clk),
    .periph_clock_o(per_clk), .clocks_active_o(active), .reset_pin_o(pin), .reset_pin_oe_o(pin_oe));
  bcg_core_model i_bcg_core_model (.clk_i(clk), .cpu_clock_i(cpu_clk), .periph_clock_i(per_clk),
    .clocks_active_i(active), .clear_i(mdl_clr), .cpu_edges_o(cpu_edges),
    .periph_edges_o(per_edges), .idle_edge_o(idle_edge));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  function automatic logic pick(input int sel);
    case (sel)
      0: return active;
      1: return pin_oe;
      2: return bus_clk;
      default: return base_clk;
    endcase
  endfunction : pick
  // Bounded wait at falling clk edges; a run-out ends the test
  task automatic wait_sig(input int sel, input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound && pick(sel) !== lvl; k++) @(negedge clk);
    if (pick(sel) !== lvl) begin
      error_cnt++;
      $display("[FAIL] wait on signal %0d expected %0d seen %0d", sel, lvl, pick(sel));
      stop_test();
    end
  endtask : wait_sig
  // Period in clk cycles between two rising edges
  task automatic measure(input int sel, output int per);
    wait_sig(sel, 1'b0, 200);
    wait_sig(sel, 1'b1, 200);
    @(negedge clk);
    per = 1;
    while (per < 200 && pick(sel) !== 1'b0) begin @(negedge clk); per++; end
    while (per < 200 && pick(sel) !== 1'b1) begin @(negedge clk); per++; end
  endtask : measure
  task automatic pulse_clr();
    mdl_clr = 1'b1;
    @(negedge clk) mdl_clr = 1'b0;
  endtask : pulse_clr
  // Stop entry, recovery choice flipped mid-stop, wake and timed recovery
  task automatic run_stop(input logic lng, input int n);
    @(negedge clk) stop_req = 1'b1;
    long_rec = lng;
    @(negedge clk) stop_req = 1'b0;
    wait_sig(0, 1'b0, 10);
    pulse_clr();
    long_rec = ~lng;
    repeat (40) @(negedge clk);
    `CHECK("clocks off in stop", 1'b0, active)
    wake = 1'b1;
    mark = osc_falls; // Fall counter has one writer, so take a snapshot
    @(negedge clk) wake = 1'b0;
    wait_sig(0, 1'b1, 40000);
    `CHECK("recovery falls in window", 1'b1, (osc_falls - mark >= n - 1 && osc_falls - mark <= n + 1))
    `CHECK("no clock edge while held", 1'b0, idle_edge)
  endtask : run_stop
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    `CHECK("oe in reset", 1'b1, pin_oe)
    `CHECK("pin level", 1'b0, pin)
    `CHECK("active in reset", 1'b0, active)
    `CHECK("bus in reset", 1'b0, bus_clk)
    reset_n = 1'b1;
    mark = osc_falls;
    @(negedge clk) mdl_clr = 1'b0;
    repeat (2000) @(negedge clk);
    `CHECK("oe mid start-up", 1'b1, pin_oe)
    wait_sig(1, 1'b0, 40000);
    `CHECK("start-up falls", 1'b1, (osc_falls - mark >= 4095 && osc_falls - mark <= 4097))
    wait_sig(0, 1'b1, 4);
    `CHECK("no edge in start-up", 1'b0, idle_edge)
    // Ordinary cases: source choice and wait gating
    foreach (rows[i]) begin
      pll_sel = rows[i].pll;
      wait_m = rows[i].wt;
      repeat (200) @(negedge clk);
      measure(2, p);
      `CHECK("bus period", rows[i].bus_p, p)
      measure(3, p);
      `CHECK("base period", rows[i].base_p, p)
      pulse_clr();
      repeat (300) @(negedge clk);
      `CHECK("cpu clock running", rows[i].cpu_run, (cpu_edges != 16'h0000))
      `CHECK("periph clock running", 1'b1, (per_edges != 16'h0000))
    end
    pll_sel = 1'b0;
    wait_m = 1'b0;
    repeat (20) @(negedge clk);
    // Awkward cases: both recovery lengths, choice changed while stopped
    run_stop(1'b0, 32);
    run_stop(1'b1, 4096);
    // Power-on event then low-voltage event while the timeout runs
    @(negedge clk) por = 1'b1;
    repeat (4) @(negedge clk);
    por = 1'b0;
    wait_sig(1, 1'b1, 10);
    wait_sig(0, 1'b0, 10);
    pulse_clr();
    // About 300 osc falls at 8 clk cycles each, bounded by cycles
    repeat (2400) @(negedge clk);
    `CHECK("oe held after event", 1'b1, pin_oe)
    lvd = 1'b1;
    repeat (4) @(negedge clk);
    lvd = 1'b0;
    repeat (400) @(negedge clk);
    `CHECK("oe held after second event", 1'b1, pin_oe)
    `CHECK("no edge after events", 1'b0, idle_edge)
    stop_test();
  end
endmodule : bus_clock_generator_bench
`default_nettype wire

// >>> verilog/bcg_bus_clock_gen.sv
// Purpose: Bus clock generator with start-up, stop-recovery and wait gating.
// Assumes: Osc, VCO, power-on and low-voltage lines are asynchronous pins.
// Notes: Clock outputs are sampled waveforms built on clk_i, far faster than osc.
// Functional notes
// - Bus runs at osc divided by four, or VCO divided by six.
// - Bus clock is the base clock divided by two.
// - After power-on or low-voltage reset hold clocks for 4096 osc cycles.
// - Drive the reset pin low throughout the start-up timeout.
// - Start bus clocks immediately when the start-up timeout ends.
// - On stop exit let the oscillator advance the system counter.
// - After stop hold clocks for 4096 or 32 osc cycles.
// - Stop the CPU clocks in wait mode.
// - Give peripherals a separate clock set that keeps running in wait.
// - Derive all clocks from one base clock, osc or PLL path.
// - System counter is 13 bits, advancing on osc falling edges.
`timescale 1ns/1ps
`default_nettype none
module bcg_bus_clock_gen (
  input wire logic clk_i, // 100 MHz system clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic osc_clock_i, // Oscillator clock pin
  input wire logic vco_clock_i, // PLL VCO clock pin
  input wire logic pll_select_i, // High selects the PLL path
  input wire logic por_i, // Power-on detect, active high
  input wire logic low_voltage_detect_i, // Low-voltage detect, active high
  input wire logic stop_req_i, // CPU enters stop mode
  input wire logic wake_i, // Interrupt, break or reset ends stop
  input wire logic wait_i, // CPU in wait mode
  input wire logic long_recovery_i, // High selects 4096-cycle recovery
  output logic base_clock_out_o, // Base clock
  output logic bus_clock_o, // Ungated bus clock
  output logic cpu_clock_o, // CPU clock set
  output logic periph_clock_o, // Peripheral clock set
  output logic clocks_active_o, // Bus clocks running
  output logic reset_pin_o, // External reset pin drive value
  output logic reset_pin_oe_o // High while pulling reset pin low
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [bcg_pkg::PIN_N-1:0] pin_raw;
  logic [bcg_pkg::PIN_N-1:0] pin_s1_q;
  logic [bcg_pkg::PIN_N-1:0] pin_s2_q;
  logic [bcg_pkg::PIN_N-1:0] pin_s3_q;

  // Release reset through two flops so all logic leaves reset together
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  assign pin_raw = {low_voltage_detect_i, por_i, vco_clock_i, osc_clock_i};

  // Two flops per pin, third stage only feeds edge detection
  genvar gi;
  generate
    for (gi = 0; gi < bcg_pkg::PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
        end
      end
    end
  endgenerate

  // Edge detection shared by both clock pins
  function automatic logic any_edge(input logic prev, input logic cur);
    any_edge = prev ^ cur;
  endfunction : any_edge

  logic osc_edge;
  logic vco_edge;
  logic osc_fall;
  logic reset_event;
  assign osc_edge = any_edge(pin_s3_q[bcg_pkg::PIN_OSC], pin_s2_q[bcg_pkg::PIN_OSC]);
  assign vco_edge = any_edge(pin_s3_q[bcg_pkg::PIN_VCO], pin_s2_q[bcg_pkg::PIN_VCO]);
  assign osc_fall = pin_s3_q[bcg_pkg::PIN_OSC] & ~pin_s2_q[bcg_pkg::PIN_OSC];
  assign reset_event = pin_s2_q[bcg_pkg::PIN_POR] | pin_s2_q[bcg_pkg::PIN_LVD];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  bcg_pkg::bcg_state_t state_q;
  logic long_q;
  logic [12:0] count;
  logic cnt_clear;
  logic cnt_adv;
  logic startup_done;
  logic recover_done;
  logic [12:0] recover_target;

  assign recover_target = long_q ? bcg_pkg::STOP_LONG_CYCLES : bcg_pkg::STOP_SHORT_CYCLES;
  assign startup_done = (count == bcg_pkg::STARTUP_CYCLES);
  assign recover_done = (count == recover_target);
  // Counter frozen in stop; osc clocks it again once stop is left
  assign cnt_adv = osc_fall && (state_q != bcg_pkg::BCG_STOP);
  assign cnt_clear = reset_event || (state_q == bcg_pkg::BCG_RUN) || (state_q == bcg_pkg::BCG_STOP);

  // Mode sequencing; a power or voltage event overrides everything
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bcg_pkg::BCG_STARTUP;
    end else if (reset_event) begin
      state_q <= bcg_pkg::BCG_STARTUP;
    end else begin
      case (state_q)
        bcg_pkg::BCG_STARTUP: begin
          if (startup_done) begin
            state_q <= bcg_pkg::BCG_RUN;
          end
        end
        bcg_pkg::BCG_RUN: begin
          if (stop_req_i) begin
            state_q <= bcg_pkg::BCG_STOP;
          end
        end
        bcg_pkg::BCG_STOP: begin
          if (wake_i) begin
            state_q <= bcg_pkg::BCG_RECOVER;
          end
        end
        bcg_pkg::BCG_RECOVER: begin
          if (recover_done) begin
            state_q <= bcg_pkg::BCG_RUN;
          end
        end
        default: begin
          state_q <= bcg_pkg::BCG_STARTUP;
        end
      endcase
    end
  end

  // Recovery length caught once at stop entry, so later changes cannot cut it short
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      long_q <= 1'b1;
    end else if (state_q == bcg_pkg::BCG_RUN && stop_req_i && !reset_event) begin
      long_q <= long_recovery_i;
    end
  end

  bcg_sys_counter u_sys_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(cnt_clear),
    .advance_i(cnt_adv),
    .count_o(count)
  );

  // ----------------------------------------------------------------
  // Base and bus clock dividers
  // ----------------------------------------------------------------
  logic pll_sel_q;
  logic [1:0] edge_cnt_q;
  logic src_edge;
  logic [1:0] edge_limit;
  logic base_q;
  logic base_toggle;
  logic bus_q;
  logic bus_d;

  // One input clock picked for everything downstream
  assign src_edge = pll_sel_q ? vco_edge : osc_edge;
  assign edge_limit = pll_sel_q ? bcg_pkg::VCO_EDGES_PER_HALF : bcg_pkg::OSC_EDGES_PER_HALF;
  assign base_toggle = src_edge && (edge_cnt_q == edge_limit - 2'h1) && (state_q != bcg_pkg::BCG_STOP);
  assign bus_d = bus_q ^ (base_toggle & ~base_q);

  // Count source edges; a source switch restarts the half period
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_sel_q <= 1'b0;
      edge_cnt_q <= bcg_pkg::EDGE_CNT_RESET;
    end else begin
      pll_sel_q <= pll_select_i;
      if (pll_sel_q != pll_select_i || state_q == bcg_pkg::BCG_STOP) begin
        edge_cnt_q <= bcg_pkg::EDGE_CNT_RESET;
      end else if (base_toggle) begin
        edge_cnt_q <= bcg_pkg::EDGE_CNT_RESET;
      end else if (src_edge) begin
        edge_cnt_q <= edge_cnt_q + 2'h1;
      end
    end
  end

  // Base toggles every half period; stop holds it low
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= 1'b0;
      bus_q <= 1'b0;
    end else if (state_q == bcg_pkg::BCG_STOP) begin
      base_q <= 1'b0;
      bus_q <= 1'b0;
    end else begin
      base_q <= base_q ^ base_toggle;
      bus_q <= bus_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and reset pin
  // ----------------------------------------------------------------
  logic run_q;
  logic cpu_run_q;
  logic cpu_clk_q;
  logic per_clk_q;
  logic rst_pin_oe_q;

  // Gates open only in run; wait closes the CPU set alone
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      cpu_run_q <= 1'b0;
    end else begin
      run_q <= (state_q == bcg_pkg::BCG_RUN) && !reset_event;
      cpu_run_q <= (state_q == bcg_pkg::BCG_RUN) && !reset_event && !wait_i;
    end
  end

  // Two clock sets so wait-capable peripherals keep ticking
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_q <= 1'b0;
      per_clk_q <= 1'b0;
    end else begin
      cpu_clk_q <= bus_d & cpu_run_q;
      per_clk_q <= bus_d & run_q;
    end
  end

  // Pin pulled low for the whole start-up timeout
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_oe_q <= 1'b1;
    end else begin
      rst_pin_oe_q <= reset_event || (state_q == bcg_pkg::BCG_STARTUP && !startup_done);
    end
  end

  assign base_clock_out_o = base_q;
  assign bus_clock_o = bus_q;
  assign cpu_clock_o = cpu_clk_q;
  assign periph_clock_o = per_clk_q;
  assign clocks_active_o = run_q;
  assign reset_pin_o = 1'b0; // Open drain: only the enable moves
  assign reset_pin_oe_o = rst_pin_oe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_in_stop;
    state_q == bcg_pkg::BCG_STOP;
  endsequence
  sequence s_startup_ends;
    state_q == bcg_pkg::BCG_STARTUP && startup_done && !reset_event;
  endsequence
  property p_half_period;
    @(posedge clk_i) disable iff (!rst_n)
      base_toggle |-> (edge_cnt_q == (pll_sel_q ? 2'h2 : 2'h1));
  endproperty
  a_half_period: assert property (p_half_period) else $error("base half period wrong");
  property p_bus_div;
    @(posedge clk_i) disable iff (!rst_n)
      ($rose(base_q) && !$past(state_q == bcg_pkg::BCG_STOP)) |-> (bus_q != $past(bus_q));
  endproperty
  a_bus_div: assert property (p_bus_div) else $error("bus did not follow base");
  property p_startup_hold;
    @(posedge clk_i) disable iff (!rst_n)
      (state_q == bcg_pkg::BCG_STARTUP) |=> !run_q && !cpu_run_q;
  endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("clocks ran during start-up");
  property p_pin_low;
    @(posedge clk_i) disable iff (!rst_n)
      (state_q == bcg_pkg::BCG_STARTUP && count < 13'h1000) |=> reset_pin_oe_o;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("reset pin released early");
  property p_start_now;
    @(posedge clk_i) disable iff (!rst_n)
      s_startup_ends ##1 !reset_event |=> run_q && !reset_pin_oe_o;
  endproperty
  a_start_now: assert property (p_start_now) else $error("clocks late after start-up");
  property p_stop_frozen;
    @(posedge clk_i) disable iff (!rst_n)
      s_in_stop |-> !cnt_adv;
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("counter ran in stop");
  property p_recover_hold;
    @(posedge clk_i) disable iff (!rst_n)
      (state_q == bcg_pkg::BCG_RECOVER && !recover_done) |=> !run_q;
  endproperty
  a_recover_hold: assert property (p_recover_hold) else $error("clocks ran during recovery");
  property p_wait_cpu;
    @(posedge clk_i) disable iff (!rst_n)
      wait_i |=> !cpu_run_q ##1 !cpu_clock_o;
  endproperty
  a_wait_cpu: assert property (p_wait_cpu) else $error("cpu clock ran in wait");
  property p_wait_periph;
    @(posedge clk_i) disable iff (!rst_n)
      (wait_i && state_q == bcg_pkg::BCG_RUN && !reset_event) |=> run_q;
  endproperty
  a_wait_periph: assert property (p_wait_periph) else $error("peripheral set stopped in wait");
  property p_long_stable;
    @(posedge clk_i) disable iff (!rst_n)
      (state_q == bcg_pkg::BCG_STOP || state_q == bcg_pkg::BCG_RECOVER) |=> $stable(long_q);
  endproperty
  a_long_stable: assert property (p_long_stable) else $error("recovery choice changed");
endmodule : bcg_bus_clock_gen
`default_nettype wire

// >>> verilog/bcg_pkg.sv
// Purpose: Shared constants for the bus clock generator.
// Assumes: Oscillator and VCO clocks arrive as plain pins sampled by clk_i.
// Notes: Delay counts are in oscillator clock cycles.
package bcg_pkg;
  // ----------------------------------------------------------------
  // Counter and delays
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 13;
  localparam logic [12:0] STARTUP_CYCLES = 13'h1000; // 4096 osc cycles
  localparam logic [12:0] STOP_LONG_CYCLES = 13'h1000; // 4096 osc cycles
  localparam logic [12:0] STOP_SHORT_CYCLES = 13'h0020; // 32 osc cycles
  localparam logic [12:0] CNT_RESET = 13'h0000;
  // ----------------------------------------------------------------
  // Divider edge counts (half periods of the base clock)
  // ----------------------------------------------------------------
  localparam logic [1:0] OSC_EDGES_PER_HALF = 2'h2; // Osc / 2 base
  localparam logic [1:0] VCO_EDGES_PER_HALF = 2'h3; // Vco / 3 base
  localparam logic [1:0] EDGE_CNT_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int unsigned PIN_N = 4;
  localparam int unsigned PIN_OSC = 0;
  localparam int unsigned PIN_VCO = 1;
  localparam int unsigned PIN_POR = 2;
  localparam int unsigned PIN_LVD = 3;
  typedef enum logic [1:0] {
    BCG_STARTUP,
    BCG_RUN,
    BCG_STOP,
    BCG_RECOVER
  } bcg_state_t;
endpackage : bcg_pkg

// >>> verilog/bcg_sys_counter.sv
// Purpose: 13-bit system counter for start-up and stop-recovery delays.
// Assumes: advance_i is a one-cycle pulse per oscillator falling edge.
// Notes: Clear has priority over advance.
`timescale 1ns/1ps
`default_nettype none
module bcg_sys_counter (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic clear_i, // Restart count from zero
  input wire logic advance_i, // Oscillator falling edge pulse
  output logic [12:0] count_o // Current count
);
  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  logic [12:0] count_q;
  // Advance on each oscillator falling edge, wrap at the top
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= bcg_pkg::CNT_RESET;
    end else if (clear_i) begin
      count_q <= bcg_pkg::CNT_RESET;
    end else if (advance_i) begin
      count_q <= count_q + 13'h0001;
    end
  end
  assign count_o = count_q;
  // Each advance moves the count by exactly one
  property p_cnt_step;
    @(posedge clk_i) disable iff (!rst_n_i)
      (advance_i && !clear_i) |=> (count_q == $past(count_q) + 13'h0001);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");
endmodule : bcg_sys_counter
`default_nettype wire
